// file: hw/pli_blink_timer.v
// Run-gated toggle generator for the identification blink
`timescale 1ns/1ps
`default_nettype none
`include "pli_regs.vh"

module pli_blink_timer #(
    parameter HALF_CYC = `PLI_BLINK_HALF_CYC,
    parameter CNT_W    = 25
) (
    // Clock and reset
    input  wire clk,
    input  wire srst,
    // Control
    input  wire run,
    // Blink phase
    output reg  phase_ff
);

    reg [CNT_W-1:0] cnt_ff;

    // Restarts from lit when idle so every blink run begins the same way
    always @(posedge clk) begin
        if (srst || !run) begin
            cnt_ff   <= {CNT_W{1'b0}};
            phase_ff <= 1'b1;
        end else if (cnt_ff == HALF_CYC[CNT_W-1:0] - 1'b1) begin
            cnt_ff   <= {CNT_W{1'b0}};
            phase_ff <= ~phase_ff;
        end else begin
            cnt_ff   <= cnt_ff + 1'b1;
        end
    end

endmodule // pli_blink_timer
`default_nettype wire

// file: hw/pli_port_led.v
// Per-port LED controller: identification blinking and in-use ownership
// Summary of operation
// - Identify off stops blinking, LEDs dark
// - Identify on toggles both port LEDs together
// - Blinking runs on until disabled
// - Green only, about three blinks per second
// - Two LEDs for each physical port
// - Identify rejected with error while sessions open
// - Session open enters in-use, cancels blinking
// - In-use holds while any session remains
// - Closing last session halts communication
// - Every command returns signed status code
`timescale 1ns/1ps
`default_nettype none
`include "pli_regs.vh"

module pli_port_led #(
    parameter HALF_CYC = `PLI_BLINK_HALF_CYC,
    parameter SESS_W   = `PLI_SESS_W
) (
    // Clock and reset
    input  wire                     clk,
    input  wire                     srst,
    // Identify command
    input  wire                     port_identify_command,
    input  wire                     identify_blink_sel,
    // Session commands
    input  wire                     session_open_command,
    input  wire                     session_close_command,
    // In-use LED pattern from the session logic
    input  wire [1:0]               inuse_green,
    input  wire [1:0]               inuse_red,
    // Command answer
    output reg                      status_valid_ff,
    output reg  [`PLI_STATUS_W-1:0] status_code_ff,
    // Port LEDs, index 0 is the lower numbered LED of the port
    output reg  [1:0]               led_green_ff,
    output reg  [1:0]               led_red_ff,
    // State indications
    output reg                      in_use_ff,
    output reg                      communication_halt_command_ff
);

    // =====================================================
    // State
    // =====================================================
    localparam [1:0] ST_IDENT = 2'b01;
    localparam [1:0] ST_INUSE = 2'b10;

    reg [1:0]        state_ff;
    reg [1:0]        nxt_state;
    reg              blink_en_ff;
    reg              nxt_blink_en;
    reg [SESS_W-1:0] sess_cnt_ff;
    reg [SESS_W-1:0] nxt_sess_cnt;
    reg              nxt_status_valid;
    reg [`PLI_STATUS_W-1:0] nxt_status_code;
    reg              nxt_halt;
    wire             phase;
    wire             sess_full;
    wire             sess_last;
    wire             sess_none;

    // =====================================================
    // Session count limits
    // =====================================================
    assign sess_full = &sess_cnt_ff;
    assign sess_last = (sess_cnt_ff == {{(SESS_W-1){1'b0}}, 1'b1});
    assign sess_none = (sess_cnt_ff == {SESS_W{1'b0}});

    // =====================================================
    // Blink timebase
    // =====================================================
    pli_blink_timer #(
        .HALF_CYC (HALF_CYC)
    ) u_timer (
        .clk      (clk),
        .srst     (srst),
        .run      (blink_en_ff),
        .phase_ff (phase)
    );

    // =====================================================
    // Command handling
    // =====================================================
    // Priority in one cycle: open, then close, then identify
    always @* begin
        nxt_state        = state_ff;
        nxt_blink_en     = blink_en_ff;
        nxt_sess_cnt     = sess_cnt_ff;
        nxt_status_valid = 1'b0;
        nxt_status_code  = `PLI_STATUS_OK;
        nxt_halt         = 1'b0;
        if (session_open_command) begin
            nxt_status_valid = 1'b1;
            if (sess_full) begin
                // Counter full: refuse rather than wrap and lose sessions
                nxt_status_code = `PLI_STATUS_ERR;
            end else begin
                nxt_sess_cnt = sess_cnt_ff + 1'b1;
                nxt_state    = ST_INUSE;
                nxt_blink_en = 1'b0;
            end
        end else if (session_close_command) begin
            nxt_status_valid = 1'b1;
            if (sess_none) begin
                nxt_status_code = `PLI_STATUS_WARN;
            end else begin
                nxt_sess_cnt = sess_cnt_ff - 1'b1;
                if (sess_last) begin
                    nxt_halt     = 1'b1;
                    nxt_state    = ST_IDENT;
                    nxt_blink_en = 1'b0;
                end else begin
                    nxt_state = ST_INUSE;
                end
            end
        end else if (port_identify_command) begin
            nxt_status_valid = 1'b1;
            case (state_ff)
                ST_IDENT: begin
                    // Held until the next identify command or session open
                    nxt_blink_en = (identify_blink_sel == `PLI_BLINK_ON);
                end
                default: begin
                    nxt_status_code = `PLI_STATUS_ERR;
                end
            endcase
        end
    end

    // =====================================================
    // Command state registers
    // =====================================================
    always @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_IDENT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            blink_en_ff <= 1'b0;
        end else begin
            blink_en_ff <= nxt_blink_en;
        end
    end

    // Count decides when the in-use state may end
    always @(posedge clk) begin
        if (srst) begin
            sess_cnt_ff <= `PLI_SESS_RST;
        end else begin
            sess_cnt_ff <= nxt_sess_cnt;
        end
    end

    // =====================================================
    // Answer and indications
    // =====================================================
    always @(posedge clk) begin
        if (srst) begin
            status_valid_ff <= 1'b0;
        end else begin
            status_valid_ff <= nxt_status_valid;
        end
    end

    // Code holds until the next answer
    always @(posedge clk) begin
        if (srst) begin
            status_code_ff <= `PLI_STATUS_OK;
        end else if (nxt_status_valid) begin
            status_code_ff <= nxt_status_code;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            communication_halt_command_ff <= 1'b0;
        end else begin
            communication_halt_command_ff <= nxt_halt;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            in_use_ff <= 1'b0;
        end else begin
            in_use_ff <= (state_ff == ST_INUSE);
        end
    end

    // =====================================================
    // LED drive
    // =====================================================
    // One cycle behind state so outputs stay registered
    always @(posedge clk) begin
        if (srst) begin
            led_green_ff <= 2'b00;
        end else if (state_ff == ST_INUSE) begin
            led_green_ff <= inuse_green;
        end else begin
            led_green_ff <= {2{blink_en_ff & phase}};
        end
    end

    // Red never lights while identifying
    always @(posedge clk) begin
        if (srst) begin
            led_red_ff <= 2'b00;
        end else if (state_ff == ST_INUSE) begin
            led_red_ff <= inuse_red;
        end else begin
            led_red_ff <= 2'b00;
        end
    end

endmodule // pli_port_led
`default_nettype wire

// file: hw/pli_regs.vh
// Constants for the per-port LED identification controller
`ifndef PLI_REGS_VH
`define PLI_REGS_VH

// Identify blink select values
`define PLI_BLINK_OFF      1'b0
`define PLI_BLINK_ON       1'b1

// Signed status codes
`define PLI_STATUS_W       8
`define PLI_STATUS_OK      8'h00
`define PLI_STATUS_WARN    8'h01
`define PLI_STATUS_ERR     8'hFF

// Blink timing: about three blinks a second, half period in ns
`define PLI_CLK_PERIOD_NS  8
`define PLI_BLINK_HALF_NS  166666667
`define PLI_BLINK_HALF_CYC (`PLI_BLINK_HALF_NS / `PLI_CLK_PERIOD_NS)

// Session counter width and reset value
`define PLI_SESS_W         8
`define PLI_SESS_RST       8'h00

`endif

// file: tb/pli_port_led_props.sv
// Assertion checker for the port LED controller
`timescale 1ns/1ps
`default_nettype none
module pli_port_led_props #(
    parameter HALF_CYC = 8
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Commands and in-use pattern
    input wire logic       port_identify_command,
    input wire logic       identify_blink_sel,
    input wire logic       session_open_command,
    input wire logic       session_close_command,
    input wire logic [1:0] inuse_green,
    input wire logic [1:0] inuse_red,
    // Answers and LEDs
    input wire logic       status_valid_ff,
    input wire logic [7:0] status_code_ff,
    input wire logic [1:0] led_green_ff,
    input wire logic [1:0] led_red_ff,
    input wire logic       in_use_ff,
    input wire logic       communication_halt_command_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [31:0] lit_run_ff;
    // Lit phase length; a stuck LED grows this past the half period
    always_ff @(posedge clk) begin
        if (srst || in_use_ff || led_green_ff == 2'h0) lit_run_ff <= 32'h0;
        else lit_run_ff <= lit_run_ff + 32'h1;
    end
    sequence s_id_ok(sel);
        port_identify_command && identify_blink_sel == sel && !session_open_command
        && !session_close_command ##1 status_code_ff == 8'h00;
    endsequence
    chk_answer_follows: assert property (
        (port_identify_command || session_open_command || session_close_command)
        |=> status_valid_ff) else $error("no answer");
    chk_ident_green_pair: assert property (
        !in_use_ff |-> led_green_ff[0] == led_green_ff[1] && led_red_ff == 2'h0)
        else $error("ident led wrong");
    chk_busy_reject: assert property (
        in_use_ff && !$past(session_close_command)
        && port_identify_command && !session_open_command && !session_close_command
        |=> status_code_ff == 8'hFF) else $error("no reject");
    chk_blink_on: assert property (
        s_id_ok(1'b1) |=> led_green_ff == 2'h3) else $error("blink not lit");
    chk_blink_off: assert property (
        s_id_ok(1'b0) |=> led_green_ff == 2'h0) else $error("leds not dark");
    chk_lit_bound: assert property (
        lit_run_ff <= HALF_CYC) else $error("blink stuck");
    chk_inuse_follow: assert property (
        in_use_ff |-> led_green_ff == $past(inuse_green) && led_red_ff == $past(inuse_red))
        else $error("in-use leds wrong");
    chk_open_inuse: assert property (
        session_open_command ##1 status_code_ff == 8'h00 |=> in_use_ff)
        else $error("open not in use");
    chk_halt_cause: assert property (
        communication_halt_command_ff |-> $past(session_close_command)
        && status_valid_ff ##1 !in_use_ff) else $error("bad halt");
endmodule // pli_port_led_props
bind pli_port_led pli_port_led_props #(.HALF_CYC(HALF_CYC)) u_pli_port_led_props (.*);
`default_nettype wire

// file: tb/tb_pli_port_led.sv
// Self-checking testbench for the port LED controller
`timescale 1ns/1ps
`default_nettype none
module tb_pli_port_led;
    logic clk = 0, srst = 1, idc = 0, sel = 0, opc = 0, clc = 0, sv, halt, inuse;
    logic [1:0] ig = 2'h1, ir = 2'h2, lg, lr;
    logic [7:0] code;
    int errors = 0, n_compared = 0, cyc = 0;
    pli_port_led #(.HALF_CYC(8)) u_pli_port_led (.clk(clk), .srst(srst),
        .port_identify_command(idc), .identify_blink_sel(sel), .session_open_command(opc),
        .session_close_command(clc), .inuse_green(ig), .inuse_red(ir), .status_valid_ff(sv),
        .status_code_ff(code), .led_green_ff(lg), .led_red_ff(lr), .in_use_ff(inuse),
        .communication_halt_command_ff(halt));
    initial forever #4 clk = ~clk;
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Issue one command, then check its answer code
    task cmd(input logic i, s, o, c, input logic [7:0] exp);
        @(posedge clk);
        {idc, sel, opc, clc} <= {i, s, o, c};
        @(posedge clk);
        {idc, opc, clc} <= 3'h0;
        #1 chk("valid", 8'h01, {7'h0, sv});
        chk("code", exp, code);
    endtask
    task t_blink;
        cmd(1, 1, 0, 0, 8'h00);
        @(posedge clk) #1 chk("lit", 8'h03, {6'h0, lg});
        chk("red", 8'h00, {6'h0, lr});
        repeat (8) @(posedge clk);
        #1 chk("dark", 8'h00, {6'h0, lg});
        repeat (8) @(posedge clk);
        #1 chk("relit", 8'h03, {6'h0, lg});
        cmd(1, 0, 0, 0, 8'h00);
        repeat (10) @(posedge clk);
        #1 chk("off", 8'h00, {6'h0, lg});
    endtask
    task t_session;
        cmd(1, 1, 0, 0, 8'h00);
        cmd(0, 0, 1, 0, 8'h00);
        @(posedge clk) #1 chk("inuse", 8'h01, {7'h0, inuse});
        chk("pattern", 8'h21, {2'h0, lr, 2'h0, lg});
        @(posedge clk) {ig, ir} <= 4'h9;
        repeat (2) @(posedge clk);
        #1 chk("pattern2", 8'h12, {2'h0, lr, 2'h0, lg});
        cmd(1, 1, 0, 0, 8'hFF);
        cmd(0, 0, 1, 0, 8'h00);
        cmd(0, 0, 0, 1, 8'h00);
        chk("halt1", 8'h00, {7'h0, halt});
        @(posedge clk) #1 chk("held", 8'h01, {7'h0, inuse});
        cmd(0, 0, 0, 1, 8'h00);
        chk("halt2", 8'h01, {7'h0, halt});
        @(posedge clk) #1 chk("free", 8'h00, {5'h0, inuse, lg});
        cmd(0, 0, 0, 1, 8'h01);
        cmd(1, 0, 0, 0, 8'h00);
    endtask
    // Fill the session counter, refuse one more, then drain it
    task t_full;
        repeat (255) cmd(0, 0, 1, 0, 8'h00);
        cmd(0, 0, 1, 0, 8'hFF);
        repeat (254) cmd(0, 0, 0, 1, 8'h00);
        chk("still", 8'h01, {7'h0, inuse});
        cmd(0, 0, 0, 1, 8'h00);
        chk("halt3", 8'h01, {7'h0, halt});
    endtask
    // Reset in mid-blink must leave LEDs, answer valid, code and halt cleared
    task t_reset;
        cmd(1, 1, 0, 0, 8'h00);
        @(posedge clk) srst <= 1;
        repeat (3) @(posedge clk);
        srst <= 0;
        #1 chk("rst", 8'h00, {2'h0, lg, lr, sv, halt});
        chk("rstcode", 8'h00, code);
        cmd(1, 0, 0, 0, 8'h00);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        srst <= 0;
        t_blink();
        t_session();
        t_full();
        t_reset();
        wrap_up();
    end
endmodule // tb_pli_port_led
`default_nettype wire
